//--- scd_pkg.sv
// Purpose: Shared constants and types for the system clock select and divide block.
// Assumes: One APB clock; the source clock is the APB clock itself.
// Notes: Register offsets and field positions are used by the block and its bench.
package scd_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_DIV_CTRL = 8'h00;
	localparam logic [7:0] OFF_SLEEP_CTRL = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;

	// ----------------------------------------
	// Field layout and reset values
	// ----------------------------------------
	localparam int DIV_EN_BIT = 7;
	localparam int FACTOR_W = 7;
	localparam int MODE_W = 3;
	localparam logic DIV_EN_RESET = 1'b0;
	localparam logic [6:0] FACTOR_RESET = 7'h00;
	localparam logic [2:0] MODE_RESET = 3'h0;
	// Status word: [2:0] state, [5:3] source class, [6] long delay, [7] divide applied
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_SRC_LSB = 3;
	localparam int STAT_LONG_BIT = 6;
	localparam int STAT_DIV_BIT = 7;

	// ----------------------------------------
	// Divider: period is 129 minus the factor, reload holds period minus one
	// ----------------------------------------
	localparam logic [7:0] DIV_RELOAD_BASE = 8'h80;
	localparam logic [6:0] FACTOR_FASTEST = 7'h7F;

	// ----------------------------------------
	// Sleep mode codes
	// ----------------------------------------
	localparam logic [2:0] MODE_IDLE = 3'h0;
	localparam logic [2:0] MODE_ADC_NR = 3'h1;
	localparam logic [2:0] MODE_PWR_DOWN = 3'h2;
	localparam logic [2:0] MODE_PWR_SAVE = 3'h3;
	localparam logic [2:0] MODE_STANDBY = 3'h6;
	localparam logic [2:0] MODE_EXT_STANDBY = 3'h7;

	// ----------------------------------------
	// Source select fuse codes (stored value, 1 = unprogrammed)
	// ----------------------------------------
	localparam logic [3:0] FUSE_EXT_CLK = 4'h0;
	localparam logic [3:0] FUSE_INT_RC_TOP = 4'h4;
	localparam logic [3:0] FUSE_EXT_RC_TOP = 4'h8;
	localparam logic [3:0] FUSE_LF_XTAL = 4'h9;

	// ----------------------------------------
	// Timing counts
	// ----------------------------------------
	localparam int RESET_SHORT_CYCLES = 4096;
	localparam int RESET_LONG_CYCLES = 65536;
	localparam int OSC_START_CYCLES = 1024;
	localparam int FUSE_SETTLE_CYCLES = 3;
	localparam int CNT_W = 17;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {SRC_EXT_CLK, SRC_INT_RC, SRC_EXT_RC, SRC_LF_XTAL, SRC_XTAL}
		scd_source_type;
	typedef enum logic [2:0] {ST_FUSE, ST_RESET_DELAY, ST_OSC_START, ST_RUN, ST_SLEEP}
		scd_state_type;
	typedef struct packed {
		logic core;
		logic periph;
		logic flash;
		logic conv;
	} scd_domain_type;

endpackage

//--- scd_divider.sv
// Purpose: Source clock divider producing a one-cycle tick per divided period.
// Assumes: Setting inputs come from registers on the same clock.
// Notes: A new setting is taken only at a period boundary.
`timescale 1ns/1ps
module scd_divider
#(
	parameter int FACTOR_W = 7
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Requested setting
	input wire logic div_on,
	input wire logic [FACTOR_W-1:0] div_factor,
	// Divided tick and setting in force
	output logic tick,
	output logic applied_on
);
	import scd_pkg::*;

	logic [FACTOR_W:0] count; // Cycles left in this period
	logic [FACTOR_W:0] next_count;
	logic next_tick;
	logic next_on;
	logic [FACTOR_W-1:0] applied_factor; // Factor of the period in progress
	logic [FACTOR_W-1:0] next_factor;

	// ----------------------------------------
	// Period counter
	// ----------------------------------------
	// Reload only at zero so no period is ever cut short
	always_comb
	begin
		next_count = count - 1'b1;
		next_tick = 1'b0;
		next_on = applied_on;
		next_factor = applied_factor;
		if (count == '0)
		begin
			next_tick = 1'b1;
			next_on = div_on;
			next_factor = div_factor;
			// Divided period is 129 minus factor; undivided ticks every cycle
			next_count = div_on ? (DIV_RELOAD_BASE - {1'b0, div_factor}) : '0;
		end
	end

	// Registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count <= '0;
			tick <= 1'b0;
			applied_on <= 1'b0;
			applied_factor <= '0;
		end
		else
		begin
			count <= next_count;
			tick <= next_tick;
			applied_on <= next_on;
			applied_factor <= next_factor;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	undiv_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
		(tick && !applied_on) |=> tick)
		else $error("undivided clock missed a tick");
	div_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
		(tick && applied_on) |=> !tick)
		else $error("divided clock tick too early");
	fastest_a: assert property (@(posedge pclk) disable iff (!presetn)
		(tick && applied_on && applied_factor == FACTOR_FASTEST) |=> !tick ##1 tick)
		else $error("divide by two period wrong");

endmodule

//--- scd_clock_ctrl.sv
// Purpose: Clock source decode, start-up timing, divider and domain gating.
// Assumes: pclk is the selected source clock; fuses and pins are asynchronous.
// Notes: Domain clocks leave as one-cycle enables for glitch-free gating cells.
//
// Summary of operation
// - Decode source kind from 4-bit fuse code
// - Fuse bit one unprogrammed, zero programmed
// - Wake from deep sleep waits oscillator start
// - Reset adds extra settling delay before running
// - Reset delay counted on watchdog oscillator
// - Reset delay is 4096 or 65536 cycles
// - Software divides source by 2 to 129
// - Enable bit divides core, peripheral, converter, flash
// - Enable bit writable while running
// - Sleep mode chooses which clocks stop
// - Stopped core clock halts all core activity
// - Async interrupt detect works without peripheral clock
// - Two-wire address match async when stopped
// - Flash clock gated with core clock
// - Async timer clock runs during sleep except power-down and standby
// - Converter clock runs in noise reduction
// - Divided frequency is source over 129-d
// - Factor field changes only while disabled
// - Setting enable takes same-write factor
// - Clearing enable discards same-write factor
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
module scd_clock_ctrl
#(
	parameter int RESET_SHORT = scd_pkg::RESET_SHORT_CYCLES,
	parameter int RESET_LONG = scd_pkg::RESET_LONG_CYCLES,
	parameter int OSC_START = scd_pkg::OSC_START_CYCLES
)
(
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [scd_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Fuses and pins (asynchronous)
	input wire logic [3:0] source_select_fuses,
	input wire logic reset_delay_fuse,
	input wire logic watchdog_oscillator,
	input wire logic wake_event,
	// Core request (same clock)
	input wire logic sleep_request,
	// Domain clock enables and status
	output scd_pkg::scd_domain_type clk_en,
	output logic async_timer_clock_run,
	output logic async_detect_en,
	output logic cpu_run,
	output scd_pkg::scd_source_type source_class
);
	import scd_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [6:0] pin_meta; // First synchroniser stage only
	logic [6:0] pin_sync; // Safe copies of the pins
	logic wd_last; // Previous watchdog level for edge find
	logic wd_edge;
	logic div_en; // Enable bit of clock_divide_control
	logic next_div_en;
	logic [FACTOR_W-1:0] factor; // Stored divide factor
	logic [FACTOR_W-1:0] next_factor;
	logic [MODE_W-1:0] mode; // Sleep mode selection
	logic [MODE_W-1:0] next_mode;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic setup_phase;
	logic wr_take;
	scd_state_type state;
	scd_state_type next_state;
	logic [CNT_W-1:0] cnt; // Shared start-up counter
	logic [CNT_W-1:0] next_cnt;
	logic [CNT_W-1:0] delay_last;
	logic [3:0] fuse_cap; // Fuses caught after reset
	logic [3:0] next_fuse_cap;
	logic long_cap; // Long reset delay chosen
	logic next_long_cap;
	logic deep_mode;
	logic div_tick;
	logic div_applied;
	scd_domain_type next_dom;
	scd_domain_type next_clk_en;
	logic next_asy;
	scd_source_type next_source;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Two flops on every pin; the edge finder looks only at the second
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_meta <= '0;
			pin_sync <= '0;
			wd_last <= 1'b0;
		end
		else
		begin
			pin_meta <= {watchdog_oscillator, wake_event, reset_delay_fuse, source_select_fuses};
			pin_sync <= pin_meta;
			wd_last <= pin_sync[6];
		end
	end

	assign wd_edge = pin_sync[6] & ~wd_last;

	// ----------------------------------------
	// APB registers
	// ----------------------------------------
	assign setup_phase = psel & ~penable;
	assign wr_take = psel & penable & pready & pwrite;

	// One wait-free access cycle; read data latched in setup
	always_comb
	begin
		next_div_en = div_en;
		next_factor = factor;
		next_mode = mode;
		next_pready = setup_phase;
		next_prdata = prdata;
		next_pslverr = 1'b0;
		if (setup_phase)
		begin
			next_prdata = '0;
			if (paddr == OFF_DIV_CTRL)
				next_prdata = {24'h0, div_en, factor};
			else if (paddr == OFF_SLEEP_CTRL)
				next_prdata = {29'h0, mode};
			else if (paddr == OFF_STATUS)
				next_prdata = {24'h0, div_applied, long_cap, source_class, state};
			else
				// Unmapped offsets answer with an error
				next_pslverr = 1'b1;
		end
		if (wr_take && paddr == OFF_DIV_CTRL)
		begin
			// Enable may change at any time, also while running
			if (pwdata[DIV_EN_BIT])
			begin
				// Factor is written only when enable goes from zero
				if (!div_en)
					next_factor = pwdata[FACTOR_W-1:0];
				next_div_en = 1'b1;
			end
			else
				// Clearing keeps the old factor
				next_div_en = 1'b0;
		end
		if (wr_take && paddr == OFF_SLEEP_CTRL)
			next_mode = pwdata[MODE_W-1:0];
	end

	// Registers of the bus group
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_en <= DIV_EN_RESET;
			factor <= FACTOR_RESET;
			mode <= MODE_RESET;
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			div_en <= next_div_en;
			factor <= next_factor;
			mode <= next_mode;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// ----------------------------------------
	// Divider
	// ----------------------------------------
	// Software trades speed for power by dividing 2 to 129
	scd_divider #(.FACTOR_W(FACTOR_W)) u_divider
	(
		.pclk(pclk),
		.presetn(presetn),
		.div_on(div_en),
		.div_factor(factor),
		.tick(div_tick),
		.applied_on(div_applied)
	);

	// ----------------------------------------
	// Start-up and sleep sequencer
	// ----------------------------------------
	// Deep modes stop the oscillator, so wake must re-time its start
	assign deep_mode = (mode == MODE_PWR_DOWN) || (mode == MODE_PWR_SAVE);
	// Programmed long-delay fuse reads zero
	assign delay_last = long_cap ? CNT_W'(RESET_LONG - 1) : CNT_W'(RESET_SHORT - 1);

	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		next_fuse_cap = fuse_cap;
		next_long_cap = long_cap;
		unique case (state)
			ST_FUSE:
			begin
				// Let the fuse synchronisers fill before catching them
				next_cnt = cnt + 1'b1;
				if (cnt == CNT_W'(FUSE_SETTLE_CYCLES - 1))
				begin
					next_fuse_cap = pin_sync[3:0];
					next_long_cap = ~pin_sync[4];
					next_cnt = '0;
					next_state = ST_RESET_DELAY;
				end
			end
			ST_RESET_DELAY:
			begin
				// Settling time counts watchdog edges, not source cycles
				if (wd_edge)
				begin
					next_cnt = cnt + 1'b1;
					if (cnt == delay_last)
					begin
						next_cnt = '0;
						next_state = ST_OSC_START;
					end
				end
			end
			ST_OSC_START:
			begin
				// Source clock itself times the oscillator start
				next_cnt = cnt + 1'b1;
				if (cnt == CNT_W'(OSC_START - 1))
				begin
					next_cnt = '0;
					next_state = ST_RUN;
				end
			end
			ST_RUN:
			begin
				if (sleep_request)
					next_state = ST_SLEEP;
			end
			ST_SLEEP:
			begin
				// Light modes keep the oscillator, so resume at once
				if (pin_sync[5])
					next_state = deep_mode ? ST_OSC_START : ST_RUN;
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= ST_FUSE;
			cnt <= '0;
			fuse_cap <= '0;
			long_cap <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			fuse_cap <= next_fuse_cap;
			long_cap <= next_long_cap;
		end
	end

	// ----------------------------------------
	// Domain gating and outputs
	// ----------------------------------------
	// Source kind from the caught fuse code
	always_comb
	begin
		if (fuse_cap == FUSE_EXT_CLK)
			next_source = SRC_EXT_CLK;
		else if (fuse_cap <= FUSE_INT_RC_TOP)
			next_source = SRC_INT_RC;
		else if (fuse_cap <= FUSE_EXT_RC_TOP)
			next_source = SRC_EXT_RC;
		else if (fuse_cap == FUSE_LF_XTAL)
			next_source = SRC_LF_XTAL;
		else
			next_source = SRC_XTAL;
	end

	// Active sleep mode picks which domains stop
	always_comb
	begin
		next_dom = '0;
		next_asy = 1'b1;
		if (state == ST_RUN)
			next_dom = '1;
		else if (state == ST_SLEEP)
		begin
			case (mode)
				MODE_IDLE:
				begin
					next_dom.periph = 1'b1;
					next_dom.conv = 1'b1;
				end
				// Converter keeps running while digital noise is quiet
				MODE_ADC_NR:
					next_dom.conv = 1'b1;
				// Asynchronous timer survives the saving modes
				MODE_PWR_DOWN, MODE_STANDBY:
					next_asy = 1'b0;
				MODE_PWR_SAVE, MODE_EXT_STANDBY:
					next_asy = 1'b1;
				// Reserved codes behave as idle
				default:
				begin
					next_dom.periph = 1'b1;
					next_dom.conv = 1'b1;
				end
			endcase
		end
		// Flash follows core so fetches never see a half-clocked core
		next_dom.flash = next_dom.core;
		// Every divided domain pulses only on the divider tick
		next_clk_en = scd_domain_type'(next_dom & {4{div_tick}});
	end

	// Output registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clk_en <= '0;
			async_timer_clock_run <= 1'b1;
			async_detect_en <= 1'b1;
			cpu_run <= 1'b0;
			source_class <= SRC_EXT_CLK;
		end
		else
		begin
			clk_en <= next_clk_en;
			async_timer_clock_run <= next_asy;
			// Async edge and address detect take over with no peripheral clock
			async_detect_en <= ~next_dom.periph;
			// Core halts register file, status and stack with its clock
			cpu_run <= next_dom.core;
			source_class <= next_source;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_div_write(logic bit7);
		wr_take && paddr == OFF_DIV_CTRL && pwdata[DIV_EN_BIT] == bit7;
	endsequence

	fuse_decode_a: assert property (
		(state == ST_RESET_DELAY && fuse_cap == FUSE_EXT_CLK) |=> source_class == SRC_EXT_CLK)
		else $error("external clock fuse code misread");
	wd_timing_a: assert property (
		(state == ST_RESET_DELAY && !wd_edge) |=> state == ST_RESET_DELAY)
		else $error("reset delay advanced without watchdog edge");
	no_core_early_a: assert property (
		(state != ST_RUN) |=> !clk_en.core && !cpu_run)
		else $error("core clock ran before start-up done");
	deep_wake_a: assert property (
		(state == ST_SLEEP && pin_sync[5] && deep_mode) |=> state == ST_OSC_START)
		else $error("deep sleep wake skipped start-up");
	set_enable_a: assert property (
		(s_div_write(1'b1) ##0 !div_en) |=> div_en && factor == $past(pwdata[FACTOR_W-1:0]))
		else $error("enable write lost its factor");
	clear_enable_a: assert property (
		s_div_write(1'b0) |=> !div_en && $stable(factor))
		else $error("disable write changed the factor");
	factor_lock_a: assert property (
		($past(div_en) && div_en) |-> $stable(factor))
		else $error("factor changed while enabled");
	flash_core_a: assert property (
		clk_en.flash == clk_en.core)
		else $error("flash clock split from core clock");
	noise_mode_a: assert property (
		(state == ST_SLEEP && mode == MODE_ADC_NR && div_tick) |=> clk_en.conv && !clk_en.periph)
		else $error("noise reduction gating wrong");
	asy_save_a: assert property (
		(state == ST_SLEEP && mode == MODE_PWR_SAVE) |=> async_timer_clock_run)
		else $error("async timer clock stopped in save mode");
	async_detect_a: assert property (
		(state == ST_SLEEP && mode == MODE_ADC_NR) |=> async_detect_en)
		else $error("async detect off with peripheral clock stopped");

endmodule

//--- scd_osc_model.sv
// Purpose: Behavioural watchdog oscillator standing beside the clock block.
// Assumes: The oscillator runs free and is unrelated in phase to pclk.
// Notes: The half period is a parameter so reset delays stay short in simulation.
`timescale 1ns/1ps
module scd_osc_model
#(
	parameter real HALF_NS = 14.1
)
(
	// Slow oscillator output
	output logic watchdog_oscillator
);
	// ----------------------------------------
	// Oscillator
	// ----------------------------------------
	// Runs free like the real part; the odd half period lets its phase drift against pclk
	initial
	begin
		watchdog_oscillator = 1'b0;
		forever #(HALF_NS) watchdog_oscillator = ~watchdog_oscillator;
	end
endmodule

//--- system_clock_select_divide_tb_top.sv
// Purpose: Self-checking bench for the clock select and divide block.
// Assumes: Watchdog oscillator comes from the partner model, about 7 pclk a period.
// Notes: Short start-up parameters keep the run brief.
`timescale 1ns/1ps
module system_clock_select_divide_tb_top;
	import scd_pkg::*;
	// ----------------------------------------
	// Settings and signals
	// ----------------------------------------
	localparam int RS = 8; // Short reset delay in watchdog cycles
	localparam int RL = 16; // Long reset delay in watchdog cycles
	localparam int OS = 4; // Oscillator start cycles
	localparam int WDC = 7; // Watchdog period in whole pclk cycles, rounded down
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [3:0] source_select_fuses = 4'hF;
	logic reset_delay_fuse = 1'b1;
	logic watchdog_oscillator;
	logic wake_event = 1'b0;
	logic sleep_request = 1'b0;
	scd_domain_type clk_en;
	logic async_timer_clock_run;
	logic async_detect_en;
	logic cpu_run;
	scd_source_type source_class;
	int fail_count = 0;
	int checked = 0;
	logic [31:0] rd;
	logic err;

	scd_osc_model osc (.watchdog_oscillator(watchdog_oscillator));
	scd_clock_ctrl #(.RESET_SHORT(RS), .RESET_LONG(RL), .OSC_START(OS)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.source_select_fuses(source_select_fuses), .reset_delay_fuse(reset_delay_fuse),
		.watchdog_oscillator(watchdog_oscillator), .wake_event(wake_event),
		.sleep_request(sleep_request), .clk_en(clk_en),
		.async_timer_clock_run(async_timer_clock_run), .async_detect_en(async_detect_en),
		.cpu_run(cpu_run), .source_class(source_class));

	// 250 MHz clock
	initial
	begin
		forever #2 pclk = ~pclk;
	end

	// ----------------------------------------
	// Expectations and tasks
	// ----------------------------------------
	// Fuse code to source kind; a stored zero is a programmed bit
	function automatic scd_source_type exp_class(input logic [3:0] f);
		if (f == 4'h0)
			return SRC_EXT_CLK;
		else if (f <= 4'h4)
			return SRC_INT_RC;
		else if (f <= 4'h8)
			return SRC_EXT_RC;
		else if (f == 4'h9)
			return SRC_LF_XTAL;
		else
			return SRC_XTAL;
	endfunction

	// Domains left running in each sleep mode; order core, periph, flash, conv
	function automatic scd_domain_type exp_dom(input logic [2:0] m);
		case (m)
			MODE_ADC_NR: return scd_domain_type'(4'h1);
			MODE_PWR_DOWN, MODE_PWR_SAVE, MODE_STANDBY, MODE_EXT_STANDBY: return '0;
			default: return scd_domain_type'(4'h5);
		endcase
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic test_done;
		if (fail_count == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// One APB transfer; request held until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Answer is taken at the very edge that sees pready high, before flops move
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		// A slave that never answers counts as a mismatch
		if (pready !== 1'b1)
			fail_count++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Cycles until the core runs, bounded so a stuck block cannot hang here
	task automatic wait_run(output int c);
		c = 0;
		while (cpu_run !== 1'b1 && c < 3000)
		begin
			@(posedge pclk);
			#1;
			c++;
		end
	endtask

	// Gap between core enables, taken on the third so the setting has settled
	task automatic core_gap(output int c);
		int k;
		for (k = 0; k < 3; k++)
		begin
			c = 0;
			do
			begin
				@(posedge pclk);
				#1;
				c++;
			end
			while (clk_en.core !== 1'b1 && c < 300);
		end
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		int cyc;
		int i;
		logic [6:0] d;
		logic [2:0] m;
		logic [2:0] modes [7];
		scd_domain_type ed;
		modes = '{MODE_IDLE, MODE_ADC_NR, MODE_PWR_DOWN, MODE_PWR_SAVE, MODE_STANDBY,
			MODE_EXT_STANDBY, 3'h4};
		void'($urandom(32'hC74ACC32));
		// Every fuse code through a full reset start-up
		for (i = 0; i < 16; i++)
		begin
			presetn <= 1'b0;
			source_select_fuses <= 4'(i);
			reset_delay_fuse <= 1'($urandom);
			repeat (4) @(posedge pclk);
			presetn <= 1'b1;
			wait_run(cyc);
			chk(32'(cyc >= (reset_delay_fuse ? RS : RL) * WDC - WDC + OS), 32'h1);
			// Upper bound too, so a start-up stuck until the wait limit cannot pass
			chk(32'(cyc <= (reset_delay_fuse ? RS : RL) * (WDC + 1) + WDC + OS + 8), 32'h1);
			chk(32'(source_class), 32'(exp_class(4'(i))));
			apb(1'b0, OFF_STATUS, 32'h0);
			chk(rd, {24'h0, 1'b0, ~reset_delay_fuse, 3'(exp_class(4'(i))), 3'h3});
		end
		// Reset values, unmapped place, read-only status
		apb(1'b0, OFF_DIV_CTRL, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, OFF_SLEEP_CTRL, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h0C, 32'h0);
		chk(32'(err), 32'h1);
		apb(1'b1, OFF_STATUS, 32'hFF);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(rd[2:0], 32'h3);
		// Divider: fastest, slowest and random factors
		for (i = 0; i < 4; i++)
		begin
			d = (i == 0) ? 7'h7F : (i == 1) ? 7'h00 : 7'($urandom);
			apb(1'b1, OFF_DIV_CTRL, {24'h0, 1'b1, d});
			core_gap(cyc);
			chk(cyc, 129 - d);
			chk(32'(clk_en), 32'hF);
			apb(1'b0, OFF_STATUS, 32'h0);
			chk(rd[7], 32'h1);
			apb(1'b1, OFF_DIV_CTRL, {24'h0, 1'b1, d ^ 7'h55});
			apb(1'b0, OFF_DIV_CTRL, 32'h0);
			chk(rd, {24'h0, 1'b1, d});
			core_gap(cyc);
			chk(cyc, 129 - d);
			apb(1'b1, OFF_DIV_CTRL, {24'h0, 1'b0, d ^ 7'h2A});
			apb(1'b0, OFF_DIV_CTRL, 32'h0);
			chk(rd, {24'h0, 1'b0, d});
			core_gap(cyc);
			chk(cyc, 32'h1);
		end
		// Every sleep mode: gating while asleep, then wake
		for (i = 0; i < 7; i++)
		begin
			m = modes[i];
			ed = exp_dom(m);
			apb(1'b1, OFF_SLEEP_CTRL, {29'h0, m});
			sleep_request <= 1'b1;
			@(posedge pclk);
			sleep_request <= 1'b0;
			repeat (4) @(posedge pclk);
			#1;
			chk(32'(cpu_run), 32'h0);
			chk(32'(clk_en), 32'(exp_dom(m)));
			chk(32'(async_timer_clock_run), 32'(m != MODE_PWR_DOWN && m != MODE_STANDBY));
			chk(32'(async_detect_en), 32'(!ed.periph));
			@(posedge pclk);
			wake_event <= 1'b1;
			wait_run(cyc);
			@(posedge pclk);
			wake_event <= 1'b0;
			chk(32'(cyc >= ((m == MODE_PWR_DOWN || m == MODE_PWR_SAVE) ? OS : 1)), 32'h1);
			chk(32'(cyc < 3000), 32'h1);
		end
		test_done();
	end

	// Watchdog against a hang
	initial
	begin
		#300000;
		fail_count++;
		test_done();
	end
endmodule
